//--- rtl/chan1_event_flags_top.sv
// The placing of the registers and strobed register access were left to the implementer.
`timescale 1ns/10ps
module chan1_event_flags_top (
  // Clock and reset
  input wire logic core_clk_in,
  input wire logic rst_n_in,
  // Register port
  input wire logic [chan1_flags_pkg::ADDR_W-1:0] addr_in,
  input wire logic [chan1_flags_pkg::DATA_W-1:0] wr_data_in,
  input wire logic wr_en_in,
  input wire logic rd_en_in,
  output logic [chan1_flags_pkg::DATA_W-1:0] rd_data_out,
  // Timer pins
  input wire logic [chan1_flags_pkg::NUM_GR-1:0] capture_in,
  input wire logic hw_standby_in,
  input wire logic sw_standby_in,
  // Interrupt
  output logic irq_out
);
  function automatic logic hit(input logic [chan1_flags_pkg::ADDR_W-1:0] a,
                               input logic [chan1_flags_pkg::ADDR_W-1:0] off);
    hit = (a == off);
  endfunction : hit

  logic rst_sync_n;
  logic [chan1_flags_pkg::SYNC_W-1:0] pins_sync;
  logic [chan1_flags_pkg::NUM_GR-1:0] cap_sync;
  logic [chan1_flags_pkg::NUM_GR-1:0] cap_prev;
  logic [chan1_flags_pkg::NUM_GR-1:0] cap_edge;
  logic standby;

  logic [chan1_flags_pkg::FLAG_W-1:0] flags;
  logic [chan1_flags_pkg::FLAG_W-1:0] armed;
  logic [chan1_flags_pkg::FLAG_W-1:0] set_vec;
  logic [chan1_flags_pkg::FLAG_W-1:0] timer_irq_enable_reg;
  logic [chan1_flags_pkg::DATA_W-1:0] ctrl;
  logic [chan1_flags_pkg::NUM_GR-1:0] mode;
  logic [chan1_flags_pkg::DATA_W-1:0] channel1_main_counter;
  logic [chan1_flags_pkg::DATA_W-1:0] general_reg [chan1_flags_pkg::NUM_GR];
  logic [7:0] div_cnt;
  logic cnt_moved;

  logic wr_flags;
  logic wr_irq;
  logic wr_ctrl;
  logic wr_mode;
  logic wr_count;
  logic wr_gr;
  logic rd_flags;
  logic rd_irq;
  logic rd_ctrl;
  logic rd_mode;
  logic rd_count;
  logic rd_gr;
  logic gr_sel;
  logic [2:0] gr_idx;
  logic run;
  logic tick;
  logic wrap_evt;
  logic irq_pend;
  logic [chan1_flags_pkg::NUM_GR-1:0] cap_evt;
  logic [chan1_flags_pkg::NUM_GR-1:0] cmp_evt;
  logic [chan1_flags_pkg::DATA_W-1:0] rd_value;
  logic [chan1_flags_pkg::FLAG_W-1:0] wr_flag_bits;

  // Reset is asserted at once and released through two flops.
  chan1_sync #(
    .WIDTH(1)
  ) u_rst_sync (
    .clk_in(core_clk_in),
    .rst_n_in(rst_n_in),
    .d_in(1'b1),
    .q_out(rst_sync_n)
  );

  chan1_sync #(
    .WIDTH(chan1_flags_pkg::SYNC_W)
  ) u_pin_sync (
    .clk_in(core_clk_in),
    .rst_n_in(rst_sync_n),
    .d_in({hw_standby_in, sw_standby_in, capture_in}),
    .q_out(pins_sync)
  );

  assign cap_sync = pins_sync[chan1_flags_pkg::NUM_GR-1:0];
  assign standby = pins_sync[9] | pins_sync[8];
  assign cap_edge = cap_sync & ~cap_prev;

  // Address decode.
  assign gr_sel = addr_in[chan1_flags_pkg::GR_SEL_BIT] & ~addr_in[0];
  assign gr_idx = addr_in[3:1];
  assign wr_flags = wr_en_in & hit(addr_in, chan1_flags_pkg::OFF_FLAGS);
  assign wr_irq = wr_en_in & hit(addr_in, chan1_flags_pkg::OFF_IRQ_EN);
  assign wr_ctrl = wr_en_in & hit(addr_in, chan1_flags_pkg::OFF_CTRL);
  assign wr_mode = wr_en_in & hit(addr_in, chan1_flags_pkg::OFF_MODE);
  assign wr_count = wr_en_in & hit(addr_in, chan1_flags_pkg::OFF_COUNT);
  assign wr_gr = wr_en_in & gr_sel;
  assign rd_flags = rd_en_in & hit(addr_in, chan1_flags_pkg::OFF_FLAGS);
  assign rd_irq = rd_en_in & hit(addr_in, chan1_flags_pkg::OFF_IRQ_EN);
  assign rd_ctrl = rd_en_in & hit(addr_in, chan1_flags_pkg::OFF_CTRL);
  assign rd_mode = rd_en_in & hit(addr_in, chan1_flags_pkg::OFF_MODE);
  assign rd_count = rd_en_in & hit(addr_in, chan1_flags_pkg::OFF_COUNT);
  assign rd_gr = rd_en_in & gr_sel;

  // Only the flag positions are taken from a write; bits 15..9 are dropped.
  assign wr_flag_bits = wr_data_in[chan1_flags_pkg::FLAG_W-1:0];

  // Counter timebase: the prescaler makes a one-cycle enable every N+1 clocks.
  assign run = ctrl[chan1_flags_pkg::CTRL_RUN_BIT];
  assign tick = run
    & (div_cnt == ctrl[chan1_flags_pkg::CTRL_DIV_MSB:chan1_flags_pkg::CTRL_DIV_LSB]);
  assign wrap_evt = tick & (channel1_main_counter == chan1_flags_pkg::COUNT_MAX);

  // Compare is checked once per new count value so a stopped counter
  // cannot keep re-setting a flag that software is trying to clear.
  assign cap_evt = cap_edge & ~mode;
  genvar i;
  generate
    for (i = 0; i < chan1_flags_pkg::NUM_GR; i++) begin : g_gr
      assign cmp_evt[i] = mode[i] & cnt_moved
        & (channel1_main_counter == general_reg[i]);

      always_ff @(posedge core_clk_in or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
          general_reg[i] <= chan1_flags_pkg::GR_RST;
        end else if (cap_evt[i]) begin
          general_reg[i] <= channel1_main_counter;
        end else if (wr_gr && gr_idx == 3'(i)) begin
          general_reg[i] <= wr_data_in;
        end
      end
    end

    // Bit 7 is register H and bit 0 register A.
    for (i = 0; i < chan1_flags_pkg::FLAG_W; i++) begin : g_flag
      chan1_flag_cell u_cell (
        .clk_in(core_clk_in),
        .rst_n_in(rst_sync_n),
        .set_in(set_vec[i]),
        .standby_in(standby),
        .read_in(rd_flags),
        .write_in(wr_flags),
        .write_bit_in(wr_flag_bits[i]),
        .flag_out(flags[i]),
        .armed_out(armed[i])
      );
    end
  endgenerate

  assign set_vec = {wrap_evt, cap_evt | cmp_evt};
  assign irq_pend = |(flags & timer_irq_enable_reg);

  assign rd_value =
    rd_flags ? {7'h00, flags} :
    rd_irq ? {7'h00, timer_irq_enable_reg} :
    rd_ctrl ? ctrl :
    rd_mode ? {8'h00, mode} :
    rd_count ? channel1_main_counter :
    rd_gr ? general_reg[gr_idx] :
    16'h0000;

  always_ff @(posedge core_clk_in or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      cap_prev <= 8'h00;
      div_cnt <= chan1_flags_pkg::DIV_RST;
      cnt_moved <= 1'b0;
    end else begin
      cap_prev <= cap_sync;
      div_cnt <= (tick || !run) ? chan1_flags_pkg::DIV_RST : div_cnt + 8'h01;
      cnt_moved <= tick;
    end
  end

  // A software write to the counter wins over a tick in the same cycle.
  always_ff @(posedge core_clk_in or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      channel1_main_counter <= chan1_flags_pkg::COUNT_RST;
    end else if (wr_count) begin
      channel1_main_counter <= wr_data_in;
    end else if (tick) begin
      channel1_main_counter <= channel1_main_counter + 16'h0001;
    end
  end

  always_ff @(posedge core_clk_in or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      timer_irq_enable_reg <= chan1_flags_pkg::IRQ_EN_RST;
      ctrl <= chan1_flags_pkg::CTRL_RST;
      mode <= chan1_flags_pkg::MODE_RST;
    end else begin
      if (wr_irq) begin
        timer_irq_enable_reg <= wr_flag_bits;
      end
      if (wr_ctrl) begin
        ctrl <= wr_data_in;
      end
      if (wr_mode) begin
        mode <= wr_data_in[chan1_flags_pkg::NUM_GR-1:0];
      end
    end
  end

  always_ff @(posedge core_clk_in or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      rd_data_out <= 16'h0000;
      irq_out <= 1'b0;
    end else begin
      rd_data_out <= rd_en_in ? rd_value : 16'h0000;
      irq_out <= irq_pend;
    end
  end

  default clocking cb @(posedge core_clk_in);
  endclocking
  default disable iff (!rst_sync_n);

  property p_reserved_zero;
    rd_flags |=> rd_data_out[15:9] == 7'h00;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero)
    else $error("reserved bits read nonzero");

  property p_layout;
    rd_flags |=> rd_data_out[8:0] == $past(flags);
  endproperty
  a_layout: assert property (p_layout)
    else $error("flag layout mismatch on read");

  property p_write_one_keeps;
    (wr_flags && !standby) |=> (($past(flags) & $past(wr_flag_bits)) & ~flags) == 9'h000;
  endproperty
  a_write_one_keeps: assert property (p_write_one_keeps)
    else $error("written one cleared a flag");

  property p_write_zero_clears;
    (wr_flags && !standby)
      |=> (($past(armed) & ~$past(wr_flag_bits) & ~$past(set_vec)) & flags) == 9'h000;
  endproperty
  a_write_zero_clears: assert property (p_write_zero_clears)
    else $error("armed zero write kept a flag");

  property p_standby_clears;
    standby |=> flags == 9'h000;
  endproperty
  a_standby_clears: assert property (p_standby_clears)
    else $error("standby left a flag set");

  property p_standby_disarms;
    standby |=> armed == 9'h000;
  endproperty
  a_standby_disarms: assert property (p_standby_disarms)
    else $error("standby left a flag armed");

  property p_wrap_sets;
    (wrap_evt && !standby)
      |=> flags[8] && (channel1_main_counter == 16'h0000 || $past(wr_count));
  endproperty
  a_wrap_sets: assert property (p_wrap_sets)
    else $error("wrap did not set flag");

  property p_wrap_cause;
    $rose(flags[8]) |-> $past(wrap_evt);
  endproperty
  a_wrap_cause: assert property (p_wrap_cause)
    else $error("wrap flag set without a wrap");

  property p_no_read_keeps;
    (flags[8] && !armed[8] && wr_flags && !wr_flag_bits[8] && !standby) |=> flags[8];
  endproperty
  a_no_read_keeps: assert property (p_no_read_keeps)
    else $error("unread wrap flag cleared");

  property p_unarmed_keeps;
    (wr_flags && !standby) |=> (($past(flags) & ~$past(armed)) & ~flags) == 9'h000;
  endproperty
  a_unarmed_keeps: assert property (p_unarmed_keeps)
    else $error("unread match flag cleared");

  property p_capture_sets;
    ((|cap_evt) && !standby) |=> (flags[7:0] & $past(cap_evt)) == $past(cap_evt);
  endproperty
  a_capture_sets: assert property (p_capture_sets)
    else $error("capture did not set flag");

  property p_compare_sets;
    ((|cmp_evt) && !standby) |=> (flags[7:0] & $past(cmp_evt)) == $past(cmp_evt);
  endproperty
  a_compare_sets: assert property (p_compare_sets)
    else $error("compare did not set flag");

  property p_capture_copies;
    cap_evt[0] |=> general_reg[0] == $past(channel1_main_counter);
  endproperty
  a_capture_copies: assert property (p_capture_copies)
    else $error("capture value wrong");

  sequence s_read_set;
    rd_flags && flags[0] && !standby;
  endsequence
  sequence s_clear_write;
    wr_flags && !wr_flag_bits[0] && !set_vec[0] && !standby;
  endsequence
  property p_read_then_clear;
    s_read_set ##1 s_clear_write |=> !flags[0];
  endproperty
  a_read_then_clear: assert property (p_read_then_clear)
    else $error("read then zero kept flag");

  property p_irq;
    1'b1 |=> irq_out == |($past(flags) & $past(timer_irq_enable_reg));
  endproperty
  a_irq: assert property (p_irq)
    else $error("interrupt output wrong");

  property p_set_wins;
    (set_vec[0] && wr_flags && !wr_flag_bits[0] && armed[0] && !standby) |=> flags[0];
  endproperty
  a_set_wins: assert property (p_set_wins)
    else $error("clear beat a set");

  property p_set_disarms;
    (set_vec[0] && wr_flags && !wr_flag_bits[0] && armed[0] && !standby) |=> !armed[0];
  endproperty
  a_set_disarms: assert property (p_set_disarms)
    else $error("collided clear left flag armed");
endmodule : chan1_event_flags_top

//--- rtl/chan1_flag_cell.sv
`timescale 1ns/10ps
module chan1_flag_cell (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // Events
  input wire logic set_in,
  input wire logic standby_in,
  // Register access
  input wire logic read_in,
  input wire logic write_in,
  input wire logic write_bit_in,
  // State
  output logic flag_out,
  output logic armed_out
);
  logic clear_req;
  logic next_flag;
  logic next_armed;

  // A zero write clears only once the set flag has been read as one.
  assign clear_req = write_in & ~write_bit_in & armed_out;
  assign next_flag = set_in | (flag_out & ~clear_req);
  // A set that collides with a clear must be read again before it can go.
  assign next_armed = next_flag & ~clear_req & (armed_out | (read_in & flag_out));

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      flag_out <= 1'b0;
      armed_out <= 1'b0;
    end else if (standby_in) begin
      flag_out <= 1'b0;
      armed_out <= 1'b0;
    end else begin
      flag_out <= next_flag;
      armed_out <= next_armed;
    end
  end
endmodule : chan1_flag_cell

//--- rtl/chan1_flags_pkg.sv
// Notes on behaviour
// - Reserved bits 15..9 always read zero.
// - Only written zero clears; one leaves flag.
// - Reset and standby clear whole register.
// - Bit 8 sets on counter wrap.
// - Wrap flag clears only after read-one, write-zero.
// - Bits 7..0 are flags H down to A.
// - Capture into general register sets its flag.
// - Counter equal to compare register sets flag.
// - All registers share one channel counter.
// - Match flag clears after read-one, write-zero.
// - Flag interrupts only when its enable set.
package chan1_flags_pkg;
  localparam int ADDR_W = 5;
  localparam int DATA_W = 16;
  localparam int NUM_GR = 8;
  localparam int FLAG_W = 9;
  localparam int WRAP_BIT = 8;
  localparam int CTRL_RUN_BIT = 0;
  localparam int CTRL_DIV_LSB = 8;
  localparam int CTRL_DIV_MSB = 15;
  localparam logic [ADDR_W-1:0] OFF_FLAGS = 5'h00;
  localparam logic [ADDR_W-1:0] OFF_IRQ_EN = 5'h02;
  localparam logic [ADDR_W-1:0] OFF_CTRL = 5'h04;
  localparam logic [ADDR_W-1:0] OFF_MODE = 5'h06;
  localparam logic [ADDR_W-1:0] OFF_COUNT = 5'h08;
  localparam int GR_SEL_BIT = 4;
  localparam logic [FLAG_W-1:0] FLAGS_RST = 9'h000;
  localparam logic [FLAG_W-1:0] IRQ_EN_RST = 9'h000;
  localparam logic [DATA_W-1:0] CTRL_RST = 16'h0000;
  localparam logic [NUM_GR-1:0] MODE_RST = 8'h00;
  localparam logic [DATA_W-1:0] COUNT_RST = 16'h0000;
  localparam logic [DATA_W-1:0] COUNT_MAX = 16'hFFFF;
  localparam logic [DATA_W-1:0] GR_RST = 16'h0000;
  localparam logic [7:0] DIV_RST = 8'h00;
  localparam int SYNC_W = 10;
endpackage : chan1_flags_pkg

//--- rtl/chan1_sync.sv
`timescale 1ns/10ps
module chan1_sync #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // Data
  input wire logic [WIDTH-1:0] d_in,
  output logic [WIDTH-1:0] q_out
);
  logic [WIDTH-1:0] meta;

  // The first stage feeds only the second stage.
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      meta <= '0;
      q_out <= '0;
    end else begin
      meta <= d_in;
      q_out <= meta;
    end
  end
endmodule : chan1_sync

//--- tb/chan1_event_flags_top_bench.sv
`timescale 1ns/10ps
module chan1_event_flags_top_bench;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [chan1_flags_pkg::ADDR_W-1:0] addr = 5'h00;
  logic [chan1_flags_pkg::DATA_W-1:0] wr_data = 16'h0000;
  logic wr_en = 1'b0;
  logic rd_en = 1'b0;
  logic [chan1_flags_pkg::DATA_W-1:0] rd_data;
  logic [chan1_flags_pkg::NUM_GR-1:0] capture = 8'h00;
  logic hw_stby = 1'b0;
  logic sw_stby = 1'b0;
  logic irq;
  logic [31:0] lfsr_state = 32'h00012915;
  int mismatches = 0;
  int num_checks = 0;

  chan1_event_flags_top u_dut (
    .core_clk_in(core_clk), .rst_n_in(rst_n), .addr_in(addr), .wr_data_in(wr_data),
    .wr_en_in(wr_en), .rd_en_in(rd_en), .rd_data_out(rd_data), .capture_in(capture),
    .hw_standby_in(hw_stby), .sw_standby_in(sw_stby), .irq_out(irq)
  );

  initial begin
    forever #2.5 core_clk = ~core_clk;
  end

  function automatic logic [15:0] flag_word(input logic [8:0] f);
    return {7'h00, f};
  endfunction : flag_word

  function automatic logic [4:0] gr_addr(input int i);
    return 5'h10 + 5'(2 * i);
  endfunction : gr_addr

  function automatic logic [15:0] next_rand();
    logic fb;
    fb = lfsr_state[31] ^ lfsr_state[21] ^ lfsr_state[1] ^ lfsr_state[0];
    lfsr_state = {lfsr_state[30:0], fb};
    return lfsr_state[15:0];
  endfunction : next_rand

  task automatic give_verdict();
    if (mismatches == 0 && num_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : give_verdict

  task automatic check_rd(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH at %0t: read %h, expected %h", $time, got, exp);
    end
  endtask : check_rd

  task automatic check_irq(input logic exp);
    num_checks++;
    if (irq !== exp) begin
      mismatches++;
      $display("MISMATCH at %0t: interrupt %b, expected %b", $time, irq, exp);
    end
  endtask : check_irq

  task automatic bus_wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge core_clk);
    addr <= a;
    wr_data <= d;
    wr_en <= 1'b1;
    @(posedge core_clk);
    wr_en <= 1'b0;
  endtask : bus_wr

  task automatic rd_check(input logic [4:0] a, input logic [15:0] exp);
    @(posedge core_clk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge core_clk);
    rd_en <= 1'b0;
    #1;
    check_rd(rd_data, exp);
  endtask : rd_check

  task automatic irq_after(input logic exp);
    repeat (2) @(posedge core_clk);
    #1;
    check_irq(exp);
  endtask : irq_after

  // The clearing write follows the read with no gap, as software would issue them.
  task automatic rd_then_clear(input logic [15:0] exp, input logic [15:0] d);
    @(posedge core_clk);
    addr <= chan1_flags_pkg::OFF_FLAGS;
    rd_en <= 1'b1;
    @(posedge core_clk);
    rd_en <= 1'b0;
    wr_data <= d;
    wr_en <= 1'b1;
    #1;
    check_rd(rd_data, exp);
    @(posedge core_clk);
    wr_en <= 1'b0;
  endtask : rd_then_clear

  // A zero written before any read must not clear; only read-one then write-zero does.
  task automatic clear_seq(input int b);
    logic [8:0] m;
    m = 9'h001 << b;
    bus_wr(chan1_flags_pkg::OFF_FLAGS, 16'h0000);
    rd_check(chan1_flags_pkg::OFF_FLAGS, flag_word(m));
    irq_after(1'b0);
    bus_wr(chan1_flags_pkg::OFF_FLAGS, 16'h01FF);
    rd_check(chan1_flags_pkg::OFF_FLAGS, flag_word(m));
    bus_wr(chan1_flags_pkg::OFF_IRQ_EN, flag_word(m));
    irq_after(1'b1);
    rd_then_clear(flag_word(m), flag_word(~m));
    rd_check(chan1_flags_pkg::OFF_FLAGS, 16'h0000);
    irq_after(1'b0);
    bus_wr(chan1_flags_pkg::OFF_IRQ_EN, 16'h0000);
  endtask : clear_seq

  // With a prescale of one the counter steps every other clock; ten clocks still reach the wrap.
  task automatic run_wrap(input logic [15:0] ctl);
    bus_wr(chan1_flags_pkg::OFF_COUNT, 16'hFFFC);
    bus_wr(chan1_flags_pkg::OFF_CTRL, ctl);
    repeat (10) @(posedge core_clk);
    bus_wr(chan1_flags_pkg::OFF_CTRL, 16'h0000);
  endtask : run_wrap

  task automatic standby(input logic hw);
    @(posedge core_clk);
    if (hw) hw_stby <= 1'b1;
    else sw_stby <= 1'b1;
    repeat (6) @(posedge core_clk);
    hw_stby <= 1'b0;
    sw_stby <= 1'b0;
    repeat (4) @(posedge core_clk);
  endtask : standby

  initial begin
    repeat (100000) @(posedge core_clk);
    mismatches++;
    give_verdict();
  end

  initial begin
    logic [15:0] v;
    repeat (12) @(posedge core_clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge core_clk);
    rd_check(chan1_flags_pkg::OFF_FLAGS, 16'h0000);
    rd_check(chan1_flags_pkg::OFF_IRQ_EN, 16'h0000);
    rd_check(chan1_flags_pkg::OFF_COUNT, 16'h0000);
    rd_check(5'h0A, 16'h0000);
    check_irq(1'b0);
    // Even indices capture, odd ones compare, so each set path meets only half the flag positions.
    for (int k = 0; k < 8; k++) begin
      v = next_rand();
      v = (v & 16'h7FFF) | 16'h0100;
      if (k % 2 == 0) begin
        bus_wr(chan1_flags_pkg::OFF_MODE, 16'h0000);
        bus_wr(chan1_flags_pkg::OFF_COUNT, v);
        @(posedge core_clk);
        capture <= capture | (8'h01 << k);
        repeat (8) @(posedge core_clk);
        capture <= 8'h00;
        repeat (4) @(posedge core_clk);
        rd_check(gr_addr(k), v);
      end else begin
        bus_wr(chan1_flags_pkg::OFF_MODE, 16'h0001 << k);
        bus_wr(gr_addr(k), v);
        bus_wr(chan1_flags_pkg::OFF_COUNT, v - 16'h0004);
        bus_wr(chan1_flags_pkg::OFF_CTRL, 16'h0001);
        repeat (10) @(posedge core_clk);
        bus_wr(chan1_flags_pkg::OFF_CTRL, 16'h0000);
      end
      clear_seq(k);
    end
    run_wrap(16'h0001);
    clear_seq(chan1_flags_pkg::WRAP_BIT);
    for (int s = 0; s < 2; s++) begin
      run_wrap((s == 0) ? 16'h0001 : 16'h0101);
      bus_wr(chan1_flags_pkg::OFF_IRQ_EN, 16'h01FF);
      rd_check(chan1_flags_pkg::OFF_FLAGS, 16'h0100);
      irq_after(1'b1);
      standby(s == 0);
      rd_check(chan1_flags_pkg::OFF_FLAGS, 16'h0000);
      irq_after(1'b0);
      rd_check(chan1_flags_pkg::OFF_IRQ_EN, 16'h01FF);
    end
    // A capture and an armed clear meet in one cycle; the flag stays and needs a new read.
    bus_wr(chan1_flags_pkg::OFF_IRQ_EN, 16'h0000);
    @(posedge core_clk);
    capture <= 8'h01;
    repeat (8) @(posedge core_clk);
    capture <= 8'h00;
    rd_check(chan1_flags_pkg::OFF_FLAGS, 16'h0001);
    repeat (4) @(posedge core_clk);
    capture <= 8'h01;
    repeat (2) @(posedge core_clk);
    addr <= chan1_flags_pkg::OFF_FLAGS;
    wr_data <= 16'h0000;
    wr_en <= 1'b1;
    @(posedge core_clk);
    wr_en <= 1'b0;
    capture <= 8'h00;
    clear_seq(0);
    give_verdict();
  end
endmodule : chan1_event_flags_top_bench
